// file: uart9_pkg.sv
/*
 * Shared constants for the eleven-bit serial link with ninth-bit address
 * filtering: frame layout, bit timing states and the register map of the
 * receiving end.
 * Assumes it is compiled before every other file of the link.
 */
// Notes on behaviour
// RQ1: Sixteen counter states make one bit period.
// RQ2: Counter held idle; line fall starts reception.
// RQ3: Start bit majority of states 7-9, else abort.
// RQ4: Data bits majority-sampled, shifted in LSB first.
// RQ5: Ninth bit state 10: load buffer if accepted.
// RQ6: Idle at stop state 10; done on strobe.
// RQ7: Rejected frame leaves buffer, ninth bit and done flag untouched.
// RQ8: Overrun keeps old buffer, sets error flag.
// RQ9: Low stop bit sets error flag on strobe.
// RQ10: Errors only set flags, never abort reception.
// RQ11: Software reads byte before next ninth bit.
// RQ12: Software sets tick rate to sixteen per bit.
// RQ13: Filter on: ninth-bit-one frames interrupt only; a low stop bit on any frame still sets the error flag and event.
// RQ14: Master sends addresses ninth one, data zero.
// RQ15: Addressed slave drops filter until end code.
// RQ16: Frame: start, eight data, ninth, stop bit.
// RQ17: Receive tick source selects timer one or two.
// RQ18: Software clears done and error flags by writing.
package uart9_pkg;

    // ----------------------------------------------------------------
    // Frame and bit timing
    // ----------------------------------------------------------------
    localparam int unsigned    FRAME_BITS    = 11;        // Start, eight data, ninth, stop.
    localparam int unsigned    DATA_BITS     = 8;         // Data bits per frame.
    localparam logic [3:0]     STATE_LAST    = 4'hF;  // Last of the sixteen counter states.
    localparam logic [3:0]     SAMPLE_FIRST  = 4'h7;  // First sampling state.
    localparam logic [3:0]     SAMPLE_MID    = 4'h8;  // Second sampling state.
    localparam logic [3:0]     SAMPLE_LAST   = 4'h9;  // Third sampling state.
    localparam logic [3:0]     DECIDE_STATE  = 4'hA;  // State where a bit is judged.
    localparam logic [3:0]     BIT_START     = 4'h0;  // Bit index of the start bit.
    localparam logic [3:0]     BIT_NINTH     = 4'h9;  // Bit index of the ninth bit.
    localparam logic [3:0]     BIT_STOP      = 4'hA;  // Bit index of the stop bit.

    // ----------------------------------------------------------------
    // Register map, byte offsets on the bus
    // ----------------------------------------------------------------
    localparam logic [7:0]     OFS_CTRL      = 8'h00;     // Control: filter and tick select.
    localparam logic [7:0]     OFS_STATUS    = 8'h04;     // Flags and busy, read only.
    localparam logic [7:0]     OFS_DATA      = 8'h08;     // Received byte, read only.
    localparam logic [7:0]     OFS_FLAG_CLR  = 8'h0C;     // Write one to clear a flag.
    localparam logic [7:0]     OFS_INT_STAT  = 8'h10;     // Sticky event bits, read only.
    localparam logic [7:0]     OFS_INT_CLR   = 8'h14;     // Write one to clear an event.
    localparam logic [7:0]     OFS_INT_EN    = 8'h18;     // Event enables.

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned    CTRL_FILTER   = 0;         // address_filter_enable.
    localparam int unsigned    CTRL_TSEL     = 1;         // 0: timer one, 1: timer two.
    localparam int unsigned    ST_DONE       = 0;         // receive_done_flag.
    localparam int unsigned    ST_ERR        = 1;         // receive_error_flag.
    localparam int unsigned    ST_NINTH      = 2;         // received_ninth_bit.
    localparam int unsigned    ST_BUSY       = 3;         // Frame in progress.
    localparam int unsigned    EV_DONE       = 0;         // Event: frame accepted.
    localparam int unsigned    EV_ERR        = 1;         // Event: overrun or framing error.
    localparam logic [1:0]     CTRL_RESET    = 2'h0;      // Filter off, timer one.
    localparam logic [1:0]     EV_RESET      = 2'h0;      // No events, all masked.

endpackage : uart9_pkg

// file: serial_link_if.sv
/*
 * The serial line between a transmitting processor and the receiver.
 * Assumes one driver, the transmitter, which holds the line high when idle.
 */
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
    logic line;  // Serial data, high when idle.

    // Receiving end only listens.
    modport rx_end (input line);
    // Transmitting end drives the line.
    modport tx_end (output line);
endinterface : serial_link_if
`default_nettype wire

// file: uart9_rx.sv
/*
 * Receiving end of the eleven-bit link: bit timing on a sixteen-state
 * counter, three-sample majority, double buffering, ninth-bit address
 * filtering, overrun and framing detection, AHB-Lite register slave and
 * a level interrupt.
 * Assumes the serial line and all inputs are synchronous to hclk, and
 * that each overflow and the cycle strobe are one-cycle pulses.
 */
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uart9_rx
(
    // Clock, reset and freeze.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              clk_en,
    // Tick sources and the flag-setting strobe.
    input  wire logic              timer1_ovf,
    input  wire logic              timer2_ovf,
    input  wire logic              cycle_one_state_three,
    // The serial line.
    serial_link_if.rx_end          link,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Interrupt.
    output logic                   irq
);
    import uart9_pkg::*;

    // ----------------------------------------------------------------
    // Types and state
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_BUSY = 1'b1} rx_state_e;

    rx_state_e   state_q;       // Idle or inside a frame.
    logic [3:0]  phase_q;       // Sixteen-state bit counter.
    logic [3:0]  bitn_q;        // Which bit of the frame is running.
    logic [2:0]  samp_q;        // Samples taken at states 7, 8 and 9.
    logic [7:0]  shift_q;       // Input shift register.
    logic [7:0]  serial_buffer; // Receive buffer seen by software.
    logic        received_ninth_bit;
    logic        receive_done_flag;
    logic        receive_error_flag;
    logic        pend_done_q;   // Done waits for the cycle strobe.
    logic        pend_err_q;    // Error waits for the cycle strobe.
    logic        accept_seen_q; // This frame was loaded into the buffer.
    logic        ovr_seen_q;    // This frame found the buffer still full.
    logic        line_prev_q;   // Line level one cycle ago.
    logic [1:0]  ctrl_q;        // Filter enable and tick select.
    logic [1:0]  ev_q;          // Sticky interrupt events.
    logic [1:0]  ev_en_q;       // Interrupt enables.
    logic        dp_wr_q;       // Data phase of a write is running.
    logic [7:0]  dp_addr_q;     // Address held for the data phase.
    logic [31:0] hrdata_q;      // Read data, registered.

    // ----------------------------------------------------------------
    // Decoding and selection
    // ----------------------------------------------------------------
    wire        tick       = clk_en & (ctrl_q[CTRL_TSEL] ? timer2_ovf : timer1_ovf); // [RQ17]
    wire        fall       = line_prev_q & ~link.line; // [RQ2]
    wire        in_sample  = (phase_q >= SAMPLE_FIRST) && (phase_q <= SAMPLE_LAST);
    wire        judge      = (state_q == RX_BUSY) && tick && (phase_q == DECIDE_STATE);
    // Majority of the three samples.
    wire        major      = (samp_q[0] & samp_q[1]) | (samp_q[0] & samp_q[2])
                           | (samp_q[1] & samp_q[2]); // [RQ3] [RQ4]
    wire        addr_ok    = ~ctrl_q[CTRL_FILTER] | major; // [RQ13]
    wire        at_ninth   = judge && (bitn_q == BIT_NINTH);
    wire        at_stop    = judge && (bitn_q == BIT_STOP);
    wire        accept     = at_ninth && addr_ok && ~receive_done_flag; // [RQ5]
    wire        overrun    = at_ninth && addr_ok && receive_done_flag; // [RQ8]
    wire        framing    = at_stop && ~major; // [RQ9]
    wire        bad_start  = judge && (bitn_q == BIT_START) && major; // [RQ3]
    wire        strobe     = clk_en & cycle_one_state_three;
    wire        set_done   = strobe & pend_done_q; // [RQ6]
    wire        set_err    = strobe & pend_err_q; // [RQ8] [RQ9]
    wire        addr_ph    = hsel & hready & htrans[1];
    wire        wr_now     = clk_en & dp_wr_q;
    wire        wr_flagclr = wr_now && (dp_addr_q == OFS_FLAG_CLR); // [RQ18]
    wire        wr_intclr  = wr_now && (dp_addr_q == OFS_INT_CLR);
    wire [31:0] rd_mux     =
        (haddr == OFS_CTRL)     ? {30'h0000_0000, ctrl_q} :
        (haddr == OFS_STATUS)   ? {28'h000_0000, state_q == RX_BUSY, received_ninth_bit,
                                   receive_error_flag, receive_done_flag} :
        (haddr == OFS_DATA)     ? {24'h00_0000, serial_buffer} :
        (haddr == OFS_INT_STAT) ? {30'h0000_0000, ev_q} :
        (haddr == OFS_INT_EN)   ? {30'h0000_0000, ev_en_q} : 32'h0000_0000;

    // The slave never stretches a transfer and never signals an error.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign irq       = |(ev_q & ev_en_q);

    // ----------------------------------------------------------------
    // Frame sequencing
    // ----------------------------------------------------------------
    // The counter rests at zero while idle, so the falling edge itself is
    // state zero of the start bit; after a false start the line must go
    // high again before a new edge can be seen.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q     <= RX_IDLE;
            phase_q     <= 4'h0;
            bitn_q      <= 4'h0;
            line_prev_q <= 1'b1;
        end
        else if (clk_en)
        begin
            line_prev_q <= link.line;
            if (state_q == RX_IDLE)
            begin
                phase_q <= 4'h0; // [RQ2]
                bitn_q  <= 4'h0;
                if (fall)
                begin
                    state_q <= RX_BUSY; // [RQ2]
                end
            end
            else if (bad_start || at_stop)
            begin
                // Back to rest; errors never shorten or stretch a frame.
                state_q <= RX_IDLE; // [RQ3] [RQ6] [RQ10]
                phase_q <= 4'h0;
            end
            else if (tick)
            begin
                phase_q <= phase_q + 4'h1; // [RQ1]
                if (phase_q == STATE_LAST)
                begin
                    bitn_q <= bitn_q + 4'h1; // [RQ1]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Sampling and shifting
    // ----------------------------------------------------------------
    // Samples are taken on the tick that ends states 7, 8 and 9, so the
    // majority is ready when state 10 is judged.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            samp_q  <= 3'h0;
            shift_q <= 8'h00;
        end
        else if (clk_en && tick && (state_q == RX_BUSY))
        begin
            if (in_sample)
            begin
                samp_q <= {samp_q[1:0], link.line}; // [RQ4]
            end
            if ((phase_q == DECIDE_STATE) && (bitn_q != BIT_START) && (bitn_q < BIT_NINTH))
            begin
                // Least significant bit arrives first, so shift right.
                shift_q <= {major, shift_q[DATA_BITS-1:1]}; // [RQ4]
            end
        end
    end

    // ----------------------------------------------------------------
    // Double buffer
    // ----------------------------------------------------------------
    // A rejected or overrun frame leaves the buffer and ninth bit alone.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            serial_buffer      <= 8'h00;
            received_ninth_bit <= 1'b0;
        end
        else if (clk_en && accept)
        begin
            serial_buffer      <= shift_q; // [RQ5] [RQ7]
            received_ninth_bit <= major; // [RQ5]
        end
    end

    // ----------------------------------------------------------------
    // Pending flags and status flags
    // ----------------------------------------------------------------
    // The overrun is noted at the ninth bit but only reported with the
    // stop bit, so both causes share one wait for the cycle strobe.
    // A hardware set wins over a software clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_done_q        <= 1'b0;
            pend_err_q         <= 1'b0;
            receive_done_flag  <= 1'b0;
            receive_error_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (accept)
            begin
                pend_done_q <= 1'b0;
            end
            else if (at_stop && (pend_done_q || accept_seen_q))
            begin
                pend_done_q <= 1'b1; // [RQ6]
            end
            else if (set_done)
            begin
                pend_done_q <= 1'b0;
            end
            if (at_stop && (ovr_seen_q || ~major))
            begin
                pend_err_q <= 1'b1; // [RQ8] [RQ9]
            end
            else if (set_err)
            begin
                pend_err_q <= 1'b0;
            end
            if (set_done)
            begin
                receive_done_flag <= 1'b1; // [RQ6] [RQ13]
            end
            else if (wr_flagclr && hwdata[ST_DONE])
            begin
                receive_done_flag <= 1'b0; // [RQ18]
            end
            if (set_err)
            begin
                receive_error_flag <= 1'b1; // [RQ10]
            end
            else if (wr_flagclr && hwdata[ST_ERR])
            begin
                receive_error_flag <= 1'b0; // [RQ18]
            end
        end
    end

    // Remembers what the ninth bit decided until the stop bit is judged.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            accept_seen_q <= 1'b0;
            ovr_seen_q    <= 1'b0;
        end
        else if (clk_en && (at_ninth || at_stop || bad_start))
        begin
            accept_seen_q <= accept; // [RQ7]
            ovr_seen_q    <= overrun; // [RQ8]
        end
    end

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    // Events follow the status flags being set; a set beats a clear.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ev_q <= EV_RESET;
        end
        else if (clk_en)
        begin
            ev_q[EV_DONE] <= set_done | (ev_q[EV_DONE] & ~(wr_intclr & hwdata[EV_DONE])); // [RQ13]
            ev_q[EV_ERR]  <= set_err  | (ev_q[EV_ERR]  & ~(wr_intclr & hwdata[EV_ERR]));
        end
    end

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // Reads are answered from the address phase so data is ready in the
    // data phase with no wait state; writes land in the data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
            ctrl_q    <= CTRL_RESET;
            ev_en_q   <= EV_RESET;
        end
        else if (clk_en)
        begin
            dp_wr_q   <= addr_ph & hwrite;
            dp_addr_q <= haddr;
            if (addr_ph && !hwrite)
            begin
                hrdata_q <= rd_mux;
            end
            if (wr_now && (dp_addr_q == OFS_CTRL))
            begin
                ctrl_q <= hwdata[1:0]; // [RQ13] [RQ17]
            end
            if (wr_now && (dp_addr_q == OFS_INT_EN))
            begin
                ev_en_q <= hwdata[1:0];
            end
        end
    end

endmodule : uart9_rx
`default_nettype wire

// file: uart9_tx.sv
/*
 * Transmitting end of the eleven-bit link: sends start bit, eight data
 * bits least significant first, the ninth bit and a stop bit.
 * Assumes bit_tick pulses sixteen times per bit period, the same rate
 * the receiving end is given.
 */
`timescale 1ns/1ps
`default_nettype none
module uart9_tx
(
    // Clock, reset and freeze.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              clk_en,
    // Sixteen ticks per bit.
    input  wire logic              bit_tick,
    // Byte to send, valid and ready handshake.
    input  wire logic              send_valid,
    output logic                   send_ready,
    input  wire logic [7:0]        send_data,
    input  wire logic              transmit_ninth_bit,
    // The serial line.
    serial_link_if.tx_end          link
);
    import uart9_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_BUSY = 1'b1} tx_state_e;

    tx_state_e   state_q;   // Idle or sending.
    logic [3:0]  phase_q;   // Sixteen-state bit counter.
    logic [3:0]  bitn_q;    // Bits already sent.
    logic [10:0] frame_q;   // Remaining frame, sent from bit zero.

    assign send_ready = (state_q == TX_IDLE);
    assign link.line  = frame_q[0];

    // ----------------------------------------------------------------
    // Shifter
    // ----------------------------------------------------------------
    // The ninth bit marks addresses with one and data with zero; the
    // user side chooses it per byte.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= TX_IDLE;
            phase_q <= 4'h0;
            bitn_q  <= 4'h0;
            frame_q <= 11'h7FF;
        end
        else if (clk_en)
        begin
            if (state_q == TX_IDLE)
            begin
                if (send_valid)
                begin
                    frame_q <= {1'b1, transmit_ninth_bit, send_data, 1'b0}; // [RQ14] [RQ16]
                    phase_q <= 4'h0;
                    bitn_q  <= 4'h0;
                    state_q <= TX_BUSY;
                end
            end
            else if (bit_tick)
            begin
                phase_q <= phase_q + 4'h1; // [RQ12]
                if (phase_q == STATE_LAST)
                begin
                    frame_q <= {1'b1, frame_q[10:1]}; // [RQ16]
                    bitn_q  <= bitn_q + 4'h1;
                    if (bitn_q == BIT_STOP)
                    begin
                        state_q <= TX_IDLE;
                    end
                end
            end
        end
    end

endmodule : uart9_tx
`default_nettype wire

// file: uart_ninth_bit_receiver_sva.sv
/* Checker for the link between the transmitting and receiving ends.
   Assumes it sits beside the link interface, fed by the bench. */
`timescale 1ns/1ps
`default_nettype none
module uart9_link_sva
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Link, transmitter and receiver signals.
    input wire logic line,
    input wire logic bit_tick,
    input wire logic send_valid,
    input wire logic send_ready,
    input wire logic cycle_one_state_three,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] tick_q; // Ticks since the frame was taken.
    // Counting only busy ticks makes a short frame visible.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) tick_q <= 8'h00;
        else if (send_ready) tick_q <= 8'h00;
        else if (bit_tick) tick_q <= tick_q + 8'h01;
    AST_IDLE_HIGH: assert property (send_ready |-> line)
        else $error("Line low while idle.");
    AST_TAKE_START: assert property (send_valid && send_ready |=> !line && !send_ready)
        else $error("No start bit after take.");
    AST_CHANGE_ON_TICK: assert property ($changed(line) |-> $past(bit_tick) || $fell(send_ready))
        else $error("Line moved between ticks.");
    AST_START_LOW: assert property (!send_ready && tick_q < 8'd16 |-> !line)
        else $error("Start bit not low.");
    AST_STOP_HIGH: assert property (tick_q >= 8'd160 |-> line)
        else $error("Stop bit not high.");
    AST_FRAME_LEN: assert property ($rose(send_ready) |-> tick_q == 8'd176)
        else $error("Frame not eleven bits.");
    AST_IRQ_ON_STROBE: assert property ($rose(irq) |-> $past(cycle_one_state_three))
        else $error("Interrupt off the strobe.");
    AST_FRAME_BUSY: assert property ($fell(send_ready) |-> !send_ready [*8])
        else $error("Frame ended early.");
    // Main scenarios: take, frame end, interrupt.
    cover property (send_valid && send_ready);
    cover property ($rose(send_ready));
    cover property ($rose(irq));
endmodule // uart9_link_sva
`default_nettype wire

// file: uart_ninth_bit_receiver_tb.sv
/* Bench: transmitter feeds receiver; a second receiver gets a bench-made line.
   Assumes the package, interface and both ends are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module uart_ninth_bit_receiver_tb;
    import uart9_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, send_valid, ninth, use2, sel2;
    logic [1:0]  htrans, tdiv = 2'h0;
    logic [2:0]  hsize, sdiv = 3'h0;
    logic [7:0]  haddr, send_data;
    logic [31:0] hwdata, rd;
    wire  [31:0] hrdata, hrdata2;
    wire         hreadyout, hreadyout2, hresp, hresp2, irq, irq2, send_ready;
    wire         tick   = (tdiv == 2'h0); // Sixteen ticks make 64 clocks per bit.
    wire         strobe = (sdiv == 3'h5); // Flag strobe every eight clocks.
    int          err_count = 0, checks_done = 0, cyc = 0;
    serial_link_if link();
    serial_link_if link2(); // Driven by the bench to inject faults.
    uart9_tx uart9_tx_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .bit_tick(tick),
        .send_valid(send_valid), .send_ready(send_ready), .send_data(send_data),
        .transmit_ninth_bit(ninth), .link(link));
    uart9_rx uart9_rx_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .timer1_ovf(tick & !use2),
        .timer2_ovf(tick & use2), .cycle_one_state_three(strobe), .link(link), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    uart9_rx uart9_rx_inst2 (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .timer1_ovf(tick & !use2),
        .timer2_ovf(tick & use2), .cycle_one_state_three(strobe), .link(link2), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata2), .hreadyout(hreadyout2), .hresp(hresp2), .irq(irq2));
    uart9_link_sva uart9_link_sva_inst (.hclk(hclk), .hresetn(hresetn), .line(link.line),
        .bit_tick(tick), .send_valid(send_valid), .send_ready(send_ready),
        .cycle_one_state_three(strobe), .irq(irq));
    initial forever #25 hclk = ~hclk;
    // Tick, strobe and hang guard share one clocked process.
    always @(posedge hclk)
    begin
        tdiv <= tdiv + 2'h1;
        sdiv <= sdiv + 3'h1;
        cyc  <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single AHB-Lite transfer; the answer is awaited, never assumed.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = sel2 ? hrdata2 : hrdata;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, rd, exp);
    endtask
    // Clear flags and events together, as software would.
    task automatic clr();
        bus(1'b1, OFS_FLAG_CLR, 32'h0000_0003);
        bus(1'b1, OFS_INT_CLR, 32'h0000_0003);
        @(posedge hclk);
    endtask
    // Send one frame and wait until the flags have landed.
    task automatic send(input logic [7:0] d, input logic n9);
        @(posedge hclk);
        send_valid <= 1'b1;
        send_data  <= d;
        ninth      <= n9;
        do @(posedge hclk); while (send_ready !== 1'b1);
        send_valid <= 1'b0;
        @(posedge hclk);
        while (send_ready !== 1'b1) @(posedge hclk);
        repeat (20) @(posedge hclk);
    endtask
    // Bench-made line: n bits of len clocks each, then idle high.
    task automatic drive(input logic [10:0] f, input int n, input int len);
        for (int i = 0; i < n; i++)
        begin
            link2.line <= f[i];
            repeat (len) @(posedge hclk);
        end
        link2.line <= 1'b1;
        repeat (300) @(posedge hclk);
    endtask
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, send_valid, send_data, ninth, use2, sel2} = '0;
        hsize = 3'b010;
        link2.line = 1'b1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("ctrl reset", OFS_CTRL, 32'h0000_0000);
        bus(1'b1, OFS_INT_EN, 32'h0000_0003);
        send(8'hA5, 1'b1);
        rdchk("status", OFS_STATUS, 32'h0000_0005);
        rdchk("data", OFS_DATA, 32'h0000_00A5);
        chk("irq", {31'h0000_0000, irq}, 32'h0000_0001);
        send(8'h3C, 1'b0);
        rdchk("overrun status", OFS_STATUS, 32'h0000_0007);
        rdchk("overrun data", OFS_DATA, 32'h0000_00A5);
        rdchk("events", OFS_INT_STAT, 32'h0000_0003);
        clr();
        chk("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
        $display("Test receive and overrun done");
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        send(8'h11, 1'b0);
        rdchk("filtered", OFS_STATUS, 32'h0000_0004);
        send(8'h22, 1'b1);
        rdchk("addressed", OFS_DATA, 32'h0000_0022);
        clr();
        use2 <= 1'b1;
        bus(1'b1, OFS_CTRL, 32'h0000_0002);
        send(8'h5A, 1'b0);
        rdchk("timer two", OFS_STATUS, 32'h0000_0001);
        rdchk("timer two data", OFS_DATA, 32'h0000_005A);
        clr();
        use2 <= 1'b0;
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        $display("Test filter and tick select done");
        sel2 = 1'b1;
        drive(11'h000, 1, 12);
        rdchk("glitch", OFS_STATUS, 32'h0000_0000);
        drive({1'b0, 1'b0, 8'h96, 1'b0}, 11, 64);
        rdchk("framing", OFS_STATUS, 32'h0000_0003);
        rdchk("framing data", OFS_DATA, 32'h0000_0096);
        chk("irq2 hresp", {30'h0000_0000, hresp, irq2}, 32'h0000_0001);
        $display("Test glitch and framing done");
        finish_test();
    end
endmodule // uart_ninth_bit_receiver_tb
`default_nettype wire
